/* File: verilog/ncc_ctrl.sv */
/*
 * flash command interface, protection bit and direct-mapped read cache.
 * assumes the peripheral bus, system bus reads, the array and the access
 * protection unit all run on sys_clk_i; array answers are one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module ncc_ctrl (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_b_i,
  // peripheral register bus
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [5:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  input  wire logic [3:0]           pstrb_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // write lock from the access_protect_unit
  input  wire logic                 wp_lock_i,
  // chip erase pulse from the device_service_unit
  input  wire logic                 dbg_erase_i,
  // system bus flash reads
  input  wire ncc_pkg::ncc_rd_req_t sb_req_i,
  output logic      [63:0]          sb_rdata_o,
  output logic                      sb_ack_o,
  // flash array
  output ncc_pkg::ncc_arr_t         arr_o,
  input  wire logic [63:0]          arr_rdata_i,
  input  wire logic                 arr_rack_i,
  input  wire logic                 arr_done_i,
  input  wire logic                 arr_fail_i,
  input  wire logic                 arr_lockerr_i,
  input  wire logic [15:0]          region_lock_i,
  // status
  output logic                      secured_o,
  output logic                      irq_o
);
  import ncc_pkg::*;

  // ==========================================================
  // helpers
  // byte-lane merge used by the config and target_location registers
  function automatic logic [31:0] bmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // commands that alter flash contents
  function automatic logic alters(input logic [6:0] c);
    return (c == C_ERASE) || (c == C_WPAGE) || (c == C_EAUX) ||
           (c == C_WAUX) || (c == C_WLOCK) || (c == C_SECURE);
  endfunction

  // ==========================================================
  // state
  logic [6:0]  code_reg;        // stored command field
  logic [7:0]  key_reg;         // stored execute_key_field
  logic        issued_reg;      // a command has been issued
  logic [31:0] cfg_reg;         // nvm_config
  logic [21:0] addr_reg;        // target_location
  logic [1:0]  ien_reg;         // irq enables
  logic        err_reg;         // error flag
  logic        program_error_flag_reg;       // program_error_flag
  logic        lock_violation_flag_reg;       // lock_violation_flag
  logic        memory_error_flag_reg;        // memory_error_flag
  logic        prm_reg;         // power_reduce_state
  logic        sec_reg;         // secured_flag
  ncc_kst_t    kst_reg;         // command sequencer
  logic [6:0]  run_reg;         // code being executed
  ncc_qst_t    qst_reg;         // read sequencer
  logic        ack_reg;
  logic [63:0] rdata_reg;
  logic        cmdp_reg;        // array command pulse
  logic [7:0]  vld_reg;         // line valid bits
  logic [15:0] tag_reg [LINES];
  logic [63:0] dat_reg [LINES];

  // ==========================================================
  // bus decode
  wire         wr     = psel_i & penable_i & pwrite_i;
  wire         w_cmd  = wr && (paddr_i == OFS_CMD);
  wire         w_cfg  = wr && (paddr_i == OFS_CFG) && !wp_lock_i;
  wire         w_addr = wr && (paddr_i == OFS_ADDR);
  wire         w_iclr = wr && (paddr_i == OFS_IECLR) && pstrb_i[0];
  wire         w_iset = wr && (paddr_i == OFS_IESET) && pstrb_i[0];
  wire         w_flg  = wr && (paddr_i == OFS_FLAGS) && pstrb_i[0];
  wire         w_st   = wr && (paddr_i == OFS_STAT) && pstrb_i[0];
  wire         mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= OFS_LOCK);
  wire         ready  = (kst_reg == K_IDLE);

  // command write with the key lane; protected lanes honour the lock
  wire         key_w  = w_cmd && pstrb_i[1] && !wp_lock_i;
  wire         key_ok = (pwdata_i[15:8] == EXEC_KEY);
  wire         go_cmd = key_w && key_ok && pstrb_i[0] && ready;
  wire         bad    = key_w && (!key_ok || !ready);
  wire         cmd_lo = w_cmd && pstrb_i[0] && !wp_lock_i;

  // ==========================================================
  // cache lookup
  wire [2:0]   idx    = sb_req_i.addr[5:3];
  wire [15:0]  tag    = sb_req_i.addr[21:6];
  wire         c_on   = !cfg_reg[CFG_OFF_B];
  wire [1:0]   pol    = cfg_reg[CFG_POL_B +: 2];
  wire         hit    = c_on && vld_reg[idx] && (tag_reg[idx] == tag);
  wire         use_c  = hit && (pol != POL_DETER);
  wire         take   = sb_req_i.valid && !ack_reg && (qst_reg == Q_IDLE) &&
                        (kst_reg != K_EXEC);
  // the command may start only with array and system bus quiet
  wire         quiet  = !sb_req_i.valid && (qst_reg == Q_IDLE);
  wire         k_fire = (kst_reg == K_WAIT) && quiet;
  wire         flush  = k_fire && ((run_reg == C_FLUSH) || alters(run_reg));
  wire         done   = (kst_reg == K_EXEC) && arr_done_i;
  wire         fill   = (qst_reg == Q_FILL) && arr_rack_i;

  // ==========================================================
  // register read mux
  logic [31:0] rd_v;
  always_comb begin
    rd_v = 32'h0;
    case (paddr_i)
      OFS_CMD:   rd_v = {16'h0, key_reg[7:1], key_reg[0] | !issued_reg,
                         1'b0, code_reg};
      OFS_CFG:   rd_v = cfg_reg;
      OFS_NVM_PARAMETERS: rd_v = {13'h0, PAGE_SZ, PAGE_CNT};
      OFS_IECLR: rd_v = {30'h0, ien_reg};
      OFS_IESET: rd_v = {30'h0, ien_reg};
      OFS_FLAGS: rd_v = {30'h0, err_reg, ready};
      OFS_STAT:  rd_v = {23'h0, sec_reg, 3'h0, memory_error_flag_reg, lock_violation_flag_reg,
                         program_error_flag_reg, 1'b0, prm_reg};
      OFS_ADDR:  rd_v = {10'h0, addr_reg};
      OFS_LOCK:  rd_v = {16'h0, region_lock_i};
      default:   rd_v = 32'h0;
    endcase
  end

  // one-cycle bus: every access completes in its access phase
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & !mapped;
  assign prdata_o  = (psel_i && !pwrite_i && mapped) ? rd_v : 32'h0;

  // ==========================================================
  // command_control storage
  // whole write lands in one cycle, so every access width is atomic
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_reg <= 7'h0;
      key_reg  <= 8'h0;
    end else begin
      if (cmd_lo && ready) begin
        code_reg <= pwdata_i[6:0];       // bit 7 never stored
      end
      if (key_w && ready) begin
        key_reg  <= pwdata_i[15:8];
      end
    end
  end

  // ==========================================================
  // configuration and address
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_reg  <= CFG_RST;
      addr_reg <= 22'h0;
    end else begin
      if (w_cfg) begin
        cfg_reg <= bmerge(cfg_reg, pwdata_i, pstrb_i) & CFG_MASK;
      end
      if (w_addr) begin
        addr_reg <= 22'(bmerge({10'h0, addr_reg}, pwdata_i, pstrb_i));
      end
    end
  end

  // ==========================================================
  // interrupt enables: ones act, zeros leave alone
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ien_reg <= 2'h0;
    end else if (w_iset) begin
      ien_reg <= ien_reg | pwdata_i[1:0];
    end else if (w_iclr) begin
      ien_reg <= ien_reg & ~pwdata_i[1:0];
    end
  end

  assign irq_o = (ien_reg[FL_READY] & ready) | (ien_reg[FL_ERROR] & err_reg);

  // ==========================================================
  // error flags: hardware set wins over a software clear
  wire ev_err   = bad || (done && arr_fail_i);
  wire ev_lock  = done && arr_lockerr_i;
  wire ev_any   = ev_err || ev_lock;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_reg   <= 1'b0;
      program_error_flag_reg <= 1'b0;
      lock_violation_flag_reg <= 1'b0;
      memory_error_flag_reg  <= 1'b0;
    end else begin
      err_reg   <= ev_any  | (err_reg   & !(w_flg && pwdata_i[FL_ERROR]));
      program_error_flag_reg <= ev_err  | (program_error_flag_reg & !(w_st && pwdata_i[ST_PROGRAM_ERROR_FLAG]));
      lock_violation_flag_reg <= ev_lock | (lock_violation_flag_reg & !(w_st && pwdata_i[ST_LOCK_VIOLATION_FLAG]));
      memory_error_flag_reg  <= (done && arr_fail_i) | (memory_error_flag_reg & !(w_st && pwdata_i[ST_MEMORY_ERROR_FLAG]));
    end
  end

  // ==========================================================
  // protection bit: set by its command, cleared only by chip erase or reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sec_reg <= 1'b0;
    end else if (done && (run_reg == C_SECURE) && !arr_fail_i) begin
      sec_reg <= 1'b1;
    end else if (dbg_erase_i) begin
      sec_reg <= 1'b0;
    end
  end

  assign secured_o = sec_reg;

  // ==========================================================
  // power reduction state follows its two commands
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prm_reg <= 1'b0;
    end else if (done && !arr_fail_i && (run_reg == C_SPRM)) begin
      prm_reg <= 1'b1;
    end else if (done && !arr_fail_i && (run_reg == C_CPRM)) begin
      prm_reg <= 1'b0;
    end
  end

  // ==========================================================
  // command sequencer
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kst_reg    <= K_IDLE;
      run_reg    <= 7'h0;
      issued_reg <= 1'b0;
      cmdp_reg   <= 1'b0;
    end else begin
      cmdp_reg <= 1'b0;
      case (kst_reg)
        // accept a keyed command; ready drops at once
        K_IDLE: begin
          if (go_cmd) begin
            run_reg <= pwdata_i[6:0];
            kst_reg <= K_WAIT;
          end
        end
        // flash reads keep priority until all is quiet
        K_WAIT: begin
          if (k_fire) begin
            issued_reg <= 1'b1;
            if (run_reg == C_FLUSH) begin
              kst_reg <= K_IDLE;
            end else begin
              cmdp_reg <= 1'b1;
              kst_reg  <= K_EXEC;
            end
          end
        end
        // wait for the array to finish
        K_EXEC: begin
          if (arr_done_i) begin
            kst_reg <= K_IDLE;
          end
        end
        default: kst_reg <= K_IDLE;
      endcase
    end
  end

  // array request: code and target travel with the command pulse
  assign arr_o.rd   = (qst_reg == Q_FILL);
  assign arr_o.cmd  = cmdp_reg;
  assign arr_o.code = run_reg;
  assign arr_o.addr = (qst_reg == Q_FILL) ? sb_req_i.addr : addr_reg;

  // ==========================================================
  // read sequencer
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      qst_reg   <= Q_IDLE;
      ack_reg   <= 1'b0;
      rdata_reg <= 64'h0;
    end else begin
      ack_reg <= 1'b0;
      case (qst_reg)
        // decide between cached answer and array fetch
        Q_IDLE: begin
          if (take) begin
            if (!use_c) begin
              qst_reg <= Q_FILL;
            end else if (pol == POL_LOWP) begin
              qst_reg <= Q_HOLD;
            end else begin
              rdata_reg <= dat_reg[idx];
              ack_reg   <= 1'b1;
            end
          end
        end
        // low power policy: one extra cycle on a hit
        Q_HOLD: begin
          rdata_reg <= dat_reg[idx];
          ack_reg   <= 1'b1;
          qst_reg   <= Q_IDLE;
        end
        // array read in flight
        Q_FILL: begin
          if (arr_rack_i) begin
            rdata_reg <= arr_rdata_i;
            ack_reg   <= 1'b1;
            qst_reg   <= Q_IDLE;
          end
        end
        default: qst_reg <= Q_IDLE;
      endcase
    end
  end

  assign sb_ack_o   = ack_reg;
  assign sb_rdata_o = rdata_reg;

  // ==========================================================
  // line valid bits: flush clears all, a fill sets one line
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vld_reg <= 8'h0;
    end else if (flush) begin
      vld_reg <= 8'h0;
    end else if (fill && c_on) begin
      vld_reg[idx] <= 1'b1;
    end
  end

  // line storage holds no reset; valid bits guard it
  always_ff @(posedge sys_clk_i) begin
    if (fill && c_on) begin
      tag_reg[idx] <= tag;
      dat_reg[idx] <= arr_rdata_i;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/ncc_pkg.sv */
/*
 * constants, types and field layout of the flash command and cache controller.
 * assumes one clock and one asynchronous active-low reset for all users.
 */
// Behaviour
// - protection bit set only by its command
// - protection stays until debugger chip erase; the reset also clears it
// - failed protection command sets program error
// - direct-mapped cache, 8 lines of 64 bits
// - cache off bit one bypasses cache
// - read policy field picks three cache modes
// - flush command invalidates every cache line
// - content-changing commands invalidate cache lines
// - byte, half and word register accesses atomic
// - locked protected registers ignore writes
// - command runs only with key 0xa5
// - wrong key drops command, sets error
// - command while busy sets program error
// - flash reads first; command waits idle
// - key bit 0 reads one until issue
// - command bit 7 reads zero
// - ready low while busy; busy writes ignored
// - code 0x46 flushes all lines
// - code 0x45 sets protection bit
package ncc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [5:0] OFS_CMD   = 6'h00; // command_control
  localparam logic [5:0] OFS_CFG   = 6'h04; // nvm_config
  localparam logic [5:0] OFS_NVM_PARAMETERS = 6'h08; // nvm_parameters
  localparam logic [5:0] OFS_IECLR = 6'h0c; // irq_enable_clear
  localparam logic [5:0] OFS_IESET = 6'h10; // irq_enable_set
  localparam logic [5:0] OFS_FLAGS = 6'h14; // irq_flags
  localparam logic [5:0] OFS_STAT  = 6'h18; // nvm_status
  localparam logic [5:0] OFS_ADDR  = 6'h1c; // target_location
  localparam logic [5:0] OFS_LOCK  = 6'h20; // region_protection
  // ==========================================================
  // fields and reset values
  localparam logic [7:0]  EXEC_KEY  = 8'ha5;
  localparam logic [31:0] CFG_MASK  = 32'h0007039e; // writable config bits
  localparam logic [31:0] CFG_RST   = 32'h00000000;
  localparam int          CFG_OFF_B = 18;           // cache_off_bit
  localparam int          CFG_POL_B = 16;           // read_policy_field low bit
  localparam logic [15:0] PAGE_CNT  = 16'h0100;     // page_count_field
  localparam logic [2:0]  PAGE_SZ   = 3'h3;         // page_size_field
  localparam int          FL_READY  = 0;
  localparam int          FL_ERROR  = 1;
  localparam int          ST_PRM    = 0;            // power_reduce_state
  localparam int          ST_PROGRAM_ERROR_FLAG  = 2;            // program_error_flag
  localparam int          ST_LOCK_VIOLATION_FLAG  = 3;            // lock_violation_flag
  localparam int          ST_MEMORY_ERROR_FLAG   = 4;            // memory_error_flag
  localparam int          ST_SECB   = 8;            // secured_flag
  // ==========================================================
  // command codes
  localparam logic [6:0] C_ERASE  = 7'h02;
  localparam logic [6:0] C_WPAGE  = 7'h04;
  localparam logic [6:0] C_EAUX   = 7'h05;
  localparam logic [6:0] C_WAUX   = 7'h06;
  localparam logic [6:0] C_WLOCK  = 7'h0f;
  localparam logic [6:0] C_SPRM   = 7'h42;
  localparam logic [6:0] C_CPRM   = 7'h43;
  localparam logic [6:0] C_SECURE = 7'h45; // set_protection_cmd
  localparam logic [6:0] C_FLUSH  = 7'h46; // flush_all_lines_cmd
  // ==========================================================
  // read policies and cache geometry
  localparam logic [1:0] POL_FAST  = 2'h0; // hit answered next cycle
  localparam logic [1:0] POL_LOWP  = 2'h1; // hit answered one cycle later
  localparam logic [1:0] POL_DETER = 2'h2; // every read goes to the array
  localparam int         LINES     = 8;
  // ==========================================================
  // types
  typedef enum logic [1:0] {K_IDLE, K_WAIT, K_EXEC} ncc_kst_t;
  typedef enum logic [1:0] {Q_IDLE, Q_HOLD, Q_FILL} ncc_qst_t;
  typedef struct packed {
    logic        valid;
    logic [21:0] addr;
  } ncc_rd_req_t;
  typedef struct packed {
    logic        rd;
    logic        cmd;
    logic [6:0]  code;
    logic [21:0] addr;
  } ncc_arr_t;
endpackage

/* File: bench/ncc_ctrl_asserts.sv */
/*
 * port checker of the flash command and cache controller.
 * assumes it is bound into every ncc_ctrl instance, one clock, async low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module ncc_ctrl_asserts
  import ncc_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        pwrite_i,
  input wire logic [5:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic [63:0] sb_rdata_o,
  input wire logic        sb_ack_o,
  input wire ncc_arr_t    arr_o,
  input wire logic [63:0] arr_rdata_i,
  input wire logic        arr_rack_i,
  input wire logic        arr_done_i,
  input wire logic        arr_fail_i,
  input wire logic        dbg_erase_i,
  input wire logic        secured_o
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire ssb_ok = arr_done_i && arr_o.code == C_SECURE && !arr_fail_i; // good protect finish
  // ==========================================================
  // properties
  chk_secure_source: assert property ($rose(secured_o) |-> $past(ssb_ok))
    else $error("protection bit set without its command");
  chk_secure_sticky: assert property (secured_o && !dbg_erase_i |=> secured_o)
    else $error("protection bit dropped without chip erase");
  chk_erase_clears: assert property (dbg_erase_i && !ssb_ok |=> !secured_o)
    else $error("chip erase left protection bit set");
  chk_read_first: assert property (arr_o.rd |-> !arr_o.cmd)
    else $error("command launched during an array read");
  chk_exec_stalls: assert property (arr_o.cmd |=> !arr_o.rd)
    else $error("array read started while command executes");
  chk_flush_local: assert property (arr_o.cmd |-> arr_o.code != C_FLUSH)
    else $error("flush command sent to the array");
  chk_fill_data: assert property (arr_o.rd && arr_rack_i |=>
    sb_ack_o && sb_rdata_o == $past(arr_rdata_i))
    else $error("array data not answered next cycle");
  chk_rsvd_zero: assert property (psel_i && !pwrite_i && paddr_i == OFS_CMD
    |-> prdata_o[7] == 1'b0)
    else $error("reserved command bit read as one");
endmodule
bind ncc_ctrl ncc_ctrl_asserts u_chk (.sys_clk_i, .rst_b_i, .psel_i, .pwrite_i, .paddr_i,
  .prdata_o, .sb_rdata_o, .sb_ack_o, .arr_o, .arr_rdata_i, .arr_rack_i, .arr_done_i,
  .arr_fail_i, .dbg_erase_i, .secured_o);
`default_nettype wire

/* File: bench/ncc_flash_model.sv */
/*
 * behavioural flash array answering reads and commands.
 * assumes the controller holds arr_i.rd until the read is answered.
 */
`timescale 1ns/1ps
`default_nettype none
module ncc_flash_model
  import ncc_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_b_i,
  input  wire ncc_arr_t arr_i,
  input  wire logic     slow_i,
  input  wire logic     fail_i,
  output logic [63:0]   rdata_o,
  output logic          rack_o,
  output logic          done_o,
  output logic          fail_o
);
  logic [3:0] wait_n; // read delay left
  logic [3:0] cmd_n;  // command time left
  wire  [63:0] pat = {arr_i.addr, ~arr_i.addr, 20'h5a3c1};
  // data only valid with the answer; inverse otherwise
  assign rdata_o = rack_o ? pat : ~pat;
  // one answer per fetch, prompt or slow; commands take four cycles
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {rack_o, done_o, fail_o, wait_n, cmd_n} <= '0;
    end else begin
      {rack_o, done_o, fail_o} <= '0;
      if (!arr_i.rd) begin
        wait_n <= slow_i ? 4'h2 : 4'h0;
      end else if (!rack_o && wait_n == 0) begin
        rack_o <= 1'b1;
      end else if (!rack_o) begin
        wait_n <= wait_n - 4'h1;
      end
      if (arr_i.cmd) begin
        cmd_n <= 4'h4;
      end else if (cmd_n == 4'h1) begin
        done_o <= 1'b1;
        fail_o <= fail_i;
        cmd_n <= 4'h0;
      end else if (cmd_n != 0) begin
        cmd_n <= cmd_n - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
/*
 * self-checking bench of the command and cache controller.
 * assumes the flash model as array and the checker bound into the design.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ncc_pkg::*;
  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
  // ==========================================================
  // signals and bench cache model
  logic        sys_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, wp_lock_i;
  logic        dbg_erase_i, pready_o, pslverr_o, sb_ack_o, secured_o, irq_o;
  logic        arr_rack_i, arr_done_i, arr_fail_i, slow, fail_cmd, re, off;
  logic [5:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rq;
  logic [3:0]  pstrb_i;
  logic [15:0] region_lock_i;
  logic [63:0] sb_rdata_o, arr_rdata_i;
  logic [7:0]  vld;
  logic [1:0]  pol;
  ncc_rd_req_t sb_req_i;
  ncc_arr_t    arr_o;
  int          fails, n_tests, tags[8];
  ncc_ctrl dut (.*, .arr_lockerr_i(1'b0));
  ncc_flash_model u_flash (.clk_i(sys_clk_i), .rst_b_i(rst_b_i), .arr_i(arr_o),
    .slow_i(slow), .fail_i(fail_cmd), .rdata_o(arr_rdata_i), .rack_o(arr_rack_i),
    .done_o(arr_done_i), .fail_o(arr_fail_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // bus tasks: one idle cycle, setup, enable; answer taken at the enable edge
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge sys_clk_i);
    #1;
    {psel_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = {1'b1, w, a, d, s};
    @(posedge sys_clk_i);
    #1;
    penable_i = 1'b1;
    @(posedge sys_clk_i);
    rq = prdata_o;
    re = pslverr_o;
    #1;
    {psel_i, penable_i} = 2'b00;
  endtask
  task automatic issue(input logic [6:0] c);
    apb(1'b1, OFS_CMD, {16'h0, EXEC_KEY, 1'b0, c}, 4'h3);
  endtask
  // poll ready before the next command
  task automatic wait_ready();
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, OFS_FLAGS, '0, 4'hf);
      if (rq[FL_READY] === 1'b1) return;
    end
    fails++;
    tally_and_finish();
  endtask
  // system read compared with the bench cache model
  task automatic sb_read(input logic [21:0] a);
    logic want;
    logic got;
    want = off || pol == POL_DETER || !vld[a[5:3]] || tags[a[5:3]] != int'(a[21:6]);
    got = 1'b0;
    slow = 1'($urandom);
    @(posedge sys_clk_i);
    #1;
    sb_req_i = '{valid: 1'b1, addr: a};
    for (int i = 0; i < 30 && sb_ack_o !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      if (arr_rack_i) got = 1'b1;
      #1;
    end
    if (sb_ack_o !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    `CHK("array fetch", want, got)
    `CHK("read data", {a, ~a, 20'h5a3c1}, sb_rdata_o)
    if (!off && pol != POL_DETER) begin
      vld[a[5:3]] = 1'b1;
      tags[a[5:3]] = int'(a[21:6]);
    end
    @(posedge sys_clk_i);
    #1;
    sb_req_i.valid = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [21:0] a;
    logic [6:0]  codes[6];
    {fails, n_tests, rst_b_i, psel_i, penable_i, pwrite_i, paddr_i} = '0;
    {pwdata_i, pstrb_i, wp_lock_i, dbg_erase_i, slow, fail_cmd, off, pol} = '0;
    {sb_req_i, region_lock_i, vld} = '0;
    void'($urandom(32'hca636597));
    region_lock_i = 16'($urandom);
    repeat (10) @(posedge sys_clk_i);
    #1;
    rst_b_i = 1'b1;
    apb(1'b0, OFS_CMD, '0, 4'hf);
    `CHK("command reg", 32'h00000100, rq)
    apb(1'b0, OFS_NVM_PARAMETERS, '0, 4'hf);
    `CHK("parameters", 32'h00030100, rq)
    apb(1'b0, OFS_LOCK, '0, 4'hf);
    `CHK("region lock", {16'h0, region_lock_i}, rq)
    apb(1'b0, 6'h24, '0, 4'hf);
    `CHK("unmapped", 33'h100000000, {re, rq})
    apb(1'b1, OFS_CMD, 32'h0000a500, 4'h2);
    apb(1'b0, OFS_FLAGS, '0, 4'hf);
    `CHK("key alone", 8'h01, rq[7:0])
    apb(1'b1, OFS_CMD, {16'h0, 8'ha4, 1'b0, C_FLUSH}, 4'h3);
    apb(1'b0, OFS_FLAGS, '0, 4'hf);
    `CHK("bad key", 8'h03, rq[7:0])
    `CHK("bus ready", 1'b1, pready_o)
    apb(1'b1, OFS_STAT, 32'h1c, 4'h1);
    apb(1'b1, OFS_FLAGS, 32'h2, 4'h1);
    wp_lock_i = 1'b1;
    apb(1'b1, OFS_CFG, 32'h00040000, 4'hf);
    apb(1'b0, OFS_CFG, '0, 4'hf);
    `CHK("locked config", 32'h0, rq)
    wp_lock_i = 1'b0;
    // failing protect command, then a write while busy
    fail_cmd = 1'b1;
    issue(C_SECURE);
    wait_ready();
    apb(1'b0, OFS_STAT, '0, 4'hf);
    `CHK("failed protect", 3'b001, {secured_o, rq[ST_SECB], rq[ST_PROGRAM_ERROR_FLAG]})
    fail_cmd = 1'b0;
    apb(1'b1, OFS_STAT, 32'h1c, 4'h1);
    apb(1'b1, OFS_FLAGS, 32'h2, 4'h1);
    issue(C_SPRM);
    issue(C_FLUSH);
    apb(1'b0, OFS_FLAGS, '0, 4'hf);
    `CHK("busy write", 8'h02, rq[7:0])
    wait_ready();
    apb(1'b0, OFS_STAT, '0, 4'hf);
    `CHK("power reduce", 2'b11, {rq[ST_PRM], rq[ST_PROGRAM_ERROR_FLAG]})
    apb(1'b1, OFS_IESET, 32'h2, 4'h1);
    `CHK("error irq", 1'b1, irq_o)
    apb(1'b1, OFS_IECLR, 32'h2, 4'h1);
    apb(1'b1, OFS_IESET, 32'h1, 4'h1);
    apb(1'b1, OFS_IECLR, 32'h0, 4'h1);
    `CHK("ready irq", 1'b1, irq_o)
    apb(1'b1, OFS_IECLR, 32'h1, 4'h1);
    `CHK("irq off", 1'b0, irq_o)
    apb(1'b1, OFS_STAT, 32'h1c, 4'h1);
    apb(1'b1, OFS_FLAGS, 32'h2, 4'h1);
    // every read policy, then the bypass
    for (int m = 0; m < 5; m++) begin
      off = (m == 4);
      pol = off ? POL_FAST : 2'(m);
      apb(1'b1, OFS_CFG, {13'h0, off, pol, 16'h0}, 4'h4);
      apb(1'b0, OFS_CFG, '0, 4'hf);
      `CHK("config", {13'h0, off, pol, 16'h0}, rq)
      issue(C_FLUSH);
      wait_ready();
      vld = '0;
      for (int i = 0; i < 12; i++) begin
        a = {14'h0, 2'($urandom), 3'($urandom), 3'h0};
        sb_read(a);
      end
    end
    // content-changing commands drop cached lines
    {off, pol} = '0;
    codes = '{C_ERASE, C_WPAGE, C_EAUX, C_WAUX, C_WLOCK, C_SECURE};
    apb(1'b1, OFS_CFG, '0, 4'hf);
    foreach (codes[k]) begin
      a = 22'(k * 8);
      sb_read(a);
      issue(codes[k]);
      wait_ready();
      vld = '0;
      sb_read(a);
    end
    `CHK("protected", 1'b1, secured_o)
    issue(C_CPRM);
    wait_ready();
    apb(1'b0, OFS_STAT, '0, 4'hf);
    `CHK("still protected", 2'b10, {secured_o, rq[ST_PRM]})
    dbg_erase_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    dbg_erase_i = 1'b0;
    `CHK("erased", 1'b0, secured_o)
    tally_and_finish();
  end
endmodule
`default_nettype wire
